// File: rtl/skl_pkg.sv
// constants and types of the serial key loader port
package skl_pkg;
  localparam int KEY_W = 64;
  localparam int CNT_W = 7;
  localparam int ADR_W = 4;
  localparam int DAT_W = 32;
  localparam int GRP_W = 8;
  localparam int NGRP = KEY_W / GRP_W;
  localparam logic [6:0] LAST_BIT = 7'h3F;
  localparam logic [6:0] CNT_ZERO = 7'h00;
  localparam logic [6:0] CNT_ONE = 7'h01;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_TKLO = 4'h8;
  localparam logic [3:0] OFS_TKHI = 4'hC;
  // control fields
  localparam int C_MODE = 0;
  localparam int C_INH = 2;
  localparam int C_START = 3;
  localparam int C_ECLR = 4;
  localparam int C_PCLR = 5;
  // status fields
  localparam int S_MODE = 0;
  localparam int S_BUSY = 2;
  localparam int S_ZERO = 3;
  localparam int S_EERR = 4;
  localparam int S_PERR = 5;
  localparam int S_IVRDY = 6;
  localparam int S_MAINT = 7;
  localparam int S_INH = 8;
  localparam int S_CNT = 9;
  localparam int STAT_W = 16;
  localparam logic [63:0] KEY_ZERO = 64'h0000000000000000;
  localparam logic [63:0] LFSR_TAPS = 64'hD800000000000000;
  localparam logic [63:0] LFSR_SEED = 64'h0000000000000001;
  localparam logic [31:0] DAT_ZERO = 32'h00000000;
  typedef enum logic [1:0] {
    SKL_CFB = 2'b00,
    SKL_CBC = 2'b01,
    SKL_OFB = 2'b10,
    SKL_ECB = 2'b11
  } skl_mode_t;
  typedef enum logic [1:0] {
    SKL_IDLE = 2'b00,
    SKL_XFER = 2'b01,
    SKL_CHECK = 2'b10
  } skl_st_t;
endpackage

// File: rtl/skl_top.sv
// serial key loader port with key storage, zeroization and iv control
//
// Summary of operation
// - request idles high, goes low only when software starts a transfer
// - only the first 64 loader clock rising edges capture bits; rest ignored
// - data and clock may serve other uses outside a transfer
// - no undesignated circuit is needed to load a key
// - odd parity per byte checked at entry and on every internal transfer
// - tamper zeroizes stored key, and iv too in chaining mode
// - key store is zeroizable; test key is exempt
// - maintenance inhibit auto-clears and test key zeroizes on leaving maintenance
// - zeroized device cannot encrypt or decrypt
// - no readout path for a plain key; test key reads zero
// - stored key survives primary power loss
// - shift buffer cleared once key reaches storage
// - new iv after key load, power return except chaining, start-up
// - every chain must begin with an iv
// - cipher feedback: iv of at least 48 bits, new per chain, plain
// - chaining: 64-bit iv, encrypted before sending, new only on key load
// - output feedback: 64-bit iv, may be sent plain
// - iv values drawn from a free-running maximal sequence
// - last iv retained across power loss
// - key bit one arrives first, bit sixty-four last
// - ciphertext suppressed while a key transfer runs
// - key is 56 random bits plus 8 odd-parity bits
`timescale 1ns/10ps
`default_nettype none
module skl_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [skl_pkg::ADR_W-1:0] addr_i,
  input wire logic [skl_pkg::DAT_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [skl_pkg::DAT_W-1:0] rdata_o,
  output logic key_req_n_o,
  input wire logic key_data_i,
  input wire logic key_clk_i,
  input wire logic tamper_i,
  input wire logic maint_i,
  input wire logic pwr_ok_i,
  input wire logic chain_start_i,
  output logic [skl_pkg::KEY_W-1:0] key_o,
  output logic [skl_pkg::KEY_W-1:0] iv_o,
  output logic iv_new_o,
  output logic iv_encrypt_o,
  output logic iv_ready_o,
  output logic cipher_en_o,
  output logic ct_inhibit_o
);
  import skl_pkg::*;

  function automatic logic par_ok(input logic [KEY_W-1:0] k);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NGRP; i++) begin
      ok = ok & (^k[i*GRP_W +: GRP_W]);
    end
    return ok;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic clk_s1, clk_s2, clk_s3;
  logic dat_s1, dat_s2;
  logic tmp_s1, tmp_s2, tmp_s3;
  logic mnt_s1, mnt_s2, mnt_s3;
  logic pwr_s1, pwr_s2, pwr_s3;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
      {dat_s1, dat_s2} <= 2'h0;
      {tmp_s1, tmp_s2, tmp_s3} <= 3'h0;
      {mnt_s1, mnt_s2, mnt_s3} <= 3'h0;
      {pwr_s1, pwr_s2, pwr_s3} <= 3'h0;
    end else if (ce_i) begin
      clk_s1 <= key_clk_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= key_data_i;
      dat_s2 <= dat_s1;
      tmp_s1 <= tamper_i;
      tmp_s2 <= tmp_s1;
      tmp_s3 <= tmp_s2;
      mnt_s1 <= maint_i;
      mnt_s2 <= mnt_s1;
      mnt_s3 <= mnt_s2;
      pwr_s1 <= pwr_ok_i;
      pwr_s2 <= pwr_s1;
      pwr_s3 <= pwr_s2;
    end
  end

  logic kclk_rise, tamper_ev, maint_exit, pwr_back;
  assign kclk_rise = clk_s2 & ~clk_s3;
  assign tamper_ev = tmp_s2 & ~tmp_s3;
  assign maint_exit = mnt_s3 & ~mnt_s2;
  assign pwr_back = pwr_s2 & ~pwr_s3;

  // ==========================================================
  // control register
  skl_mode_t mode;
  logic inhibit;
  logic [KEY_W-1:0] tkey;
  logic wr_ctrl, start, zeroize, iv_zero;

  assign wr_ctrl = wr_i & (addr_i == OFS_CTRL);
  assign start = wr_ctrl & wdata_i[C_START];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode <= SKL_CFB;
    end else if (ce_i && wr_ctrl) begin
      mode <= skl_mode_t'(wdata_i[C_MODE +: 2]);
    end
  end

  // inhibit settable only inside the opened case
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      inhibit <= 1'b0;
    end else if (ce_i) begin
      if (maint_exit || !mnt_s2) begin
        inhibit <= 1'b0;
      end else if (wr_ctrl) begin
        inhibit <= wdata_i[C_INH];
      end
    end
  end

  // test key is exempt from tamper zeroize but dies on maintenance exit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tkey <= KEY_ZERO;
    end else if (ce_i) begin
      if (maint_exit) begin
        tkey <= KEY_ZERO;
      end else if (wr_i && mnt_s2 && addr_i == OFS_TKLO) begin
        tkey[DAT_W-1:0] <= wdata_i;
      end else if (wr_i && mnt_s2 && addr_i == OFS_TKHI) begin
        tkey[KEY_W-1:DAT_W] <= wdata_i;
      end
    end
  end

  assign zeroize = tamper_ev & ~inhibit;
  assign iv_zero = zeroize & (mode == SKL_CBC);

  // ==========================================================
  // serial transfer state machine
  skl_st_t st;
  logic [KEY_W-1:0] sr;
  logic [CNT_W-1:0] cnt;
  logic commit, bad_key;

  // the loader clock is oversampled, so it must stay well below clk_i/4
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= SKL_IDLE;
      key_req_n_o <= 1'b1;
      cnt <= CNT_ZERO;
      sr <= KEY_ZERO;
    end else if (ce_i) begin
      case (st)
        SKL_IDLE: begin
          if (start && pwr_s2) begin
            st <= SKL_XFER;
            key_req_n_o <= 1'b0;
            cnt <= CNT_ZERO;
          end
        end
        SKL_XFER: begin
          if (zeroize || !pwr_s2) begin
            st <= SKL_IDLE;
            key_req_n_o <= 1'b1;
            sr <= KEY_ZERO;
          end else if (kclk_rise) begin
            sr <= {sr[KEY_W-2:0], dat_s2};
            cnt <= cnt + CNT_ONE;
            if (cnt == LAST_BIT) begin
              st <= SKL_CHECK;
              key_req_n_o <= 1'b1;
            end
          end
        end
        SKL_CHECK: begin
          st <= SKL_IDLE;
          sr <= KEY_ZERO;
        end
        default: begin
          st <= SKL_IDLE;
          key_req_n_o <= 1'b1;
        end
      endcase
    end
  end

  // clock edges outside a transfer change nothing here
  assign commit = (st == SKL_CHECK) & par_ok(sr);
  assign bad_key = (st == SKL_CHECK) & ~par_ok(sr);

  // ==========================================================
  // key storage, battery domain: primary power loss does not touch it
  logic [KEY_W-1:0] key_store;
  logic key_valid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_store <= KEY_ZERO;
      key_valid <= 1'b0;
    end else if (ce_i) begin
      if (zeroize) begin
        key_store <= KEY_ZERO;
        key_valid <= 1'b0;
      end else if (commit && !zeroize) begin
        key_store <= sr;
        key_valid <= 1'b1;
      end
    end
  end

  // working copy to the cipher core, parity checked on every move
  logic [KEY_W-1:0] key_src;
  logic src_ok, par_alarm, entry_err;
  assign key_src = mnt_s2 ? tkey : key_store;
  assign src_ok = par_ok(key_src);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      key_o <= KEY_ZERO;
    end else if (ce_i) begin
      key_o <= src_ok ? key_src : KEY_ZERO;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      par_alarm <= 1'b0;
    end else if (ce_i) begin
      if ((key_valid || mnt_s2) && !src_ok) begin
        par_alarm <= 1'b1;
      end else if (wr_ctrl && wdata_i[C_PCLR]) begin
        par_alarm <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      entry_err <= 1'b0;
    end else if (ce_i) begin
      if (bad_key) begin
        entry_err <= 1'b1;
      end else if (wr_ctrl && wdata_i[C_ECLR]) begin
        entry_err <= 1'b0;
      end
    end
  end

  // ==========================================================
  // cipher gating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cipher_en_o <= 1'b0;
      ct_inhibit_o <= 1'b1;
    end else if (ce_i) begin
      cipher_en_o <= key_valid & pwr_s2 & src_ok & (st == SKL_IDLE);
      ct_inhibit_o <= (st != SKL_IDLE) | ~key_valid | ~pwr_s2;
    end
  end

  // ==========================================================
  // initializing vector
  logic [KEY_W-1:0] lfsr;
  logic iv_need;

  // runs every cycle; requests land at unpredictable phases of it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lfsr <= LFSR_SEED;
    end else if (ce_i) begin
      lfsr <= {lfsr[KEY_W-2:0], ^(lfsr & LFSR_TAPS)};
    end
  end

  // reset puts iv_need high: a start-up always draws a new vector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      iv_need <= 1'b1;
    end else if (ce_i) begin
      if (commit || iv_zero) begin
        iv_need <= 1'b1;
      end else if (pwr_back && mode != SKL_CBC) begin
        iv_need <= 1'b1;
      end else if (chain_start_i && mode == SKL_CFB) begin
        iv_need <= 1'b1;
      end else if (key_valid && pwr_s2) begin
        iv_need <= 1'b0;
      end
    end
  end

  // full 64-bit vector serves all modes, above the 48-bit floor
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      iv_o <= KEY_ZERO;
      iv_new_o <= 1'b0;
    end else if (ce_i) begin
      iv_new_o <= 1'b0;
      if (iv_zero) begin
        iv_o <= KEY_ZERO;
      end else if (iv_need && key_valid && pwr_s2) begin
        iv_o <= lfsr;
        iv_new_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      iv_encrypt_o <= 1'b0;
      iv_ready_o <= 1'b0;
    end else if (ce_i) begin
      iv_encrypt_o <= (mode == SKL_CBC);
      iv_ready_o <= ~iv_need & key_valid & ~chain_start_i;
    end
  end

  // ==========================================================
  // register read port; keys never appear here
  logic [STAT_W-1:0] stat;
  always_comb begin
    stat = '0;
    stat[S_MODE +: 2] = mode;
    stat[S_BUSY] = (st != SKL_IDLE);
    stat[S_ZERO] = ~key_valid;
    stat[S_EERR] = entry_err;
    stat[S_PERR] = par_alarm;
    stat[S_IVRDY] = iv_ready_o;
    stat[S_MAINT] = mnt_s2;
    stat[S_INH] = inhibit;
    stat[S_CNT +: CNT_W] = cnt;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= DAT_ZERO;
    end else if (ce_i) begin
      rdata_o <= DAT_ZERO;
      if (rd_i) begin
        case (addr_i)
          OFS_CTRL: rdata_o <= {26'h0, 1'b0, 1'b0, 1'b0, inhibit, mode};
          OFS_STAT: rdata_o <= {16'h0, stat};
          default: rdata_o <= DAT_ZERO;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  sequence s_last_bit;
    st == SKL_XFER && kclk_rise && cnt == LAST_BIT && !zeroize && pwr_s2;
  endsequence

  sequence s_release;
    key_req_n_o ##1 st == SKL_IDLE;
  endsequence

  a_req_idle_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st == SKL_IDLE && !start) |=> key_req_n_o)
    else $error("request low without a start");

  a_req_release: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    s_last_bit |=> s_release)
    else $error("request not released after last bit");

  a_extra_clk_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st == SKL_IDLE && kclk_rise) |=> $stable(sr))
    else $error("bit taken outside a transfer");

  a_buf_cleared: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st == SKL_CHECK) |=> (sr == KEY_ZERO))
    else $error("shift buffer not cleared");

  a_bad_key_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (bad_key && !zeroize) |=> (entry_err && $stable(key_store)))
    else $error("bad key stored or unflagged");

  a_tamper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    zeroize |=> (!key_valid && key_store == KEY_ZERO) ##1 !cipher_en_o)
    else $error("tamper did not zeroize");

  a_ct_suppress: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (st != SKL_IDLE) |=> (ct_inhibit_o && !cipher_en_o))
    else $error("ciphertext allowed during transfer");

  a_maint_exit: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    maint_exit |=> (!inhibit && tkey == KEY_ZERO))
    else $error("maintenance exit left inhibit or test key");

  a_iv_after_load: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (commit && !zeroize && pwr_s2) |-> ##[1:3] iv_new_o)
    else $error("no new iv after key load");

  a_key_out_parity: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cipher_en_o |-> par_ok(key_o))
    else $error("key with bad parity in use");
endmodule
`default_nettype wire

// File: dv/skl_loader.sv
// behavioural model of the handheld key loader on the far side of the link
`timescale 1ns/10ps
`default_nettype none
module skl_loader (
  input wire logic key_req_n_i,
  input wire logic [63:0] key_i,
  input wire logic [3:0] extra_i,
  output logic key_clk_o,
  output logic key_data_o
);
  int n;
  // ==========================================================
  // frame generator: clock stands low between frames
  initial begin
    key_clk_o = 1'b0;
    key_data_o = 1'b0;
    forever begin
      @(negedge key_req_n_i);
      #200;
      // extra cycles beyond 64 carry junk, as a sloppy loader might
      for (n = 0; n < 64 + extra_i; n++) begin
        key_data_o = (n < 64) ? key_i[63 - n] : ~key_data_o;
        #80 key_clk_o = 1'b1;
        #80 key_clk_o = 1'b0;
      end
      // released data line has no pull, so it must not keep the last bit
      #80 key_data_o = ~key_data_o;
    end
  end
endmodule
`default_nettype wire

// File: dv/skl_top_tb.sv
// self-checking testbench of the serial key loader port
`timescale 1ns/10ps
`default_nettype none
module skl_top_tb;
  import skl_pkg::*;
  logic clk_i, rst_n_i, ce_i, wr_i, rd_i, key_data_i, key_clk_i;
  logic tamper_i, maint_i, pwr_ok_i, chain_start_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic key_req_n_o, iv_new_o, iv_encrypt_o, iv_ready_o, cipher_en_o, ct_inhibit_o;
  logic [63:0] key_o, iv_o, lkey;
  logic [3:0] lextra;
  int fail_count, checked, iv_cnt, w;
  localparam logic [63:0] GOOD = 64'h1325498F01020480;
  localparam logic [63:0] BAD = 64'h1325498F01020481;

  skl_top u_skl_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .key_req_n_o(key_req_n_o),
    .key_data_i(key_data_i), .key_clk_i(key_clk_i), .tamper_i(tamper_i), .maint_i(maint_i),
    .pwr_ok_i(pwr_ok_i), .chain_start_i(chain_start_i), .key_o(key_o), .iv_o(iv_o),
    .iv_new_o(iv_new_o), .iv_encrypt_o(iv_encrypt_o), .iv_ready_o(iv_ready_o),
    .cipher_en_o(cipher_en_o), .ct_inhibit_o(ct_inhibit_o));
  skl_loader u_skl_loader (.key_req_n_i(key_req_n_o), .key_i(lkey), .extra_i(lextra),
    .key_clk_o(key_clk_i), .key_data_o(key_data_i));

  // ==========================================================
  // clock, iv pulse monitor, watchdog
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // counted mid-cycle so tasks reading iv_cnt at a rising edge never race it
  always @(negedge clk_i) begin
    if (iv_new_o === 1'b1) iv_cnt++;
  end
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // loader keeps no undesignated circuits at all
  task automatic load(input logic [63:0] k, input logic [3:0] x);
    lkey = k;
    lextra = x;
    wr(OFS_CTRL, 32'h00000008);
    #1 chk("req low", 1'b0, key_req_n_o);
    cyc(100);
    #1 chk("ct inhibit", 1'b1, ct_inhibit_o);
    for (w = 0; w < 2000 && key_req_n_o !== 1'b1; w++) @(posedge clk_i);
    chk("req released", 1'b1, key_req_n_o);
    cyc(200);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("req idle", 1'b1, key_req_n_o);
    chk("cipher off", 1'b0, cipher_en_o);
    chk("key zero", KEY_ZERO, key_o);
    $display("test reset done");
  endtask
  task automatic t_good;
    int c0;
    c0 = iv_cnt;
    load(GOOD, 4'h5);
    chk("key stored", GOOD, key_o);
    chk("cipher on", 1'b1, cipher_en_o);
    chk("iv renewed", 1'b1, iv_cnt > c0);
    chk("ct free", 1'b0, ct_inhibit_o);
    chk("iv ready", 1'b1, iv_ready_o);
    rd(OFS_TKLO, d);
    chk("no key readout", DAT_ZERO, d);
    $display("test good load done");
  endtask
  task automatic t_bad;
    load(BAD, 4'h0);
    chk("old key kept", GOOD, key_o);
    rd(OFS_STAT, d);
    chk("entry error", 1'b1, d[S_EERR]);
    wr(OFS_CTRL, 32'h00000010);
    rd(OFS_STAT, d);
    chk("entry error cleared", 1'b0, d[S_EERR]);
    $display("test bad parity done");
  endtask
  task automatic t_modes;
    int c0;
    wr(OFS_CTRL, 32'h00000001);
    cyc(3);
    chk("cbc encrypt iv", 1'b1, iv_encrypt_o);
    c0 = iv_cnt;
    chain_start_i <= 1'b1;
    cyc(1);
    chain_start_i <= 1'b0;
    cyc(5);
    chk("cbc no new iv", c0, iv_cnt);
    wr(OFS_CTRL, 32'h00000002);
    cyc(3);
    chk("ofb plain iv", 1'b0, iv_encrypt_o);
    wr(OFS_CTRL, 32'h00000000);
    c0 = iv_cnt;
    chain_start_i <= 1'b1;
    cyc(1);
    chain_start_i <= 1'b0;
    cyc(5);
    chk("cfb new iv", c0 + 1, iv_cnt);
    pwr_ok_i <= 1'b0;
    cyc(10);
    chk("cipher off power", 1'b0, cipher_en_o);
    pwr_ok_i <= 1'b1;
    cyc(10);
    chk("key survives", GOOD, key_o);
    chk("iv after power", 1'b1, iv_cnt > c0 + 1);
    $display("test modes done");
  endtask
  task automatic t_tamper;
    maint_i <= 1'b1;
    cyc(6);
    wr(OFS_CTRL, 32'h00000004);
    wr(OFS_TKLO, 32'h1325498F);
    wr(OFS_TKHI, 32'h01020480);
    cyc(4);
    chk("test key used", 64'h010204801325498F, key_o);
    rd(OFS_TKHI, d);
    chk("no test key readout", DAT_ZERO, d);
    tamper_i <= 1'b1;
    cyc(4);
    tamper_i <= 1'b0;
    cyc(8);
    maint_i <= 1'b0;
    cyc(8);
    rd(OFS_STAT, d);
    chk("inhibit cleared", 1'b0, d[S_INH]);
    chk("parity alarm", 1'b1, d[S_PERR]);
    chk("key kept", GOOD, key_o);
    // chaining mode, so the tamper must take the vector as well
    wr(OFS_CTRL, 32'h00000021);
    tamper_i <= 1'b1;
    cyc(4);
    tamper_i <= 1'b0;
    cyc(8);
    chk("key zeroized", KEY_ZERO, key_o);
    chk("iv zeroized", KEY_ZERO, iv_o);
    chk("cipher blocked", 1'b0, cipher_en_o);
    rd(OFS_STAT, d);
    chk("zero flag", 1'b1, d[S_ZERO]);
    chk("parity alarm cleared", 1'b0, d[S_PERR]);
    $display("test tamper done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 4'h0;
    wdata_i = 32'h00000000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    tamper_i = 1'b0;
    maint_i = 1'b0;
    pwr_ok_i = 1'b1;
    chain_start_i = 1'b0;
    lkey = 64'h0;
    lextra = 4'h0;
    cyc(12);
    rst_n_i <= 1'b1;
    cyc(4);
    #1 t_reset();
    t_good();
    t_bad();
    t_modes();
    t_tamper();
    finish_test();
  end
endmodule
`default_nettype wire
